// file: hdl/ddrp_phy.sv
// ddr phy clocking, command registering, write strobe sequencing and lane array
//
// Behaviour
// - drive memory a continuous free-running clock, low jitter, documented 200MHz/5ns; here clk/2, 8ns with the 4ns local clock
// - all interface clocks come from the dedicated low-jitter reference clock
// - two internal clock phases 180 degrees apart; inverted one runs control
// - address, bank, ras, cas, we each registered in a control-phase output flop
// - command and address change midway between memory clock rising edges
// - write data and mask launched from write-clock registers
// - clock manager gets fixed phase shift setting of +182
// - interface drives the strobes itself during writes, aligned to write data
// - read data captured per lane with a delayed copy of its own strobe
// - each bank's dummy keep input drives its dummy output directly
// - lane n is dq 8n..8n+7, strobe n, mask n, kept together
`timescale 1ns/1ps
module ddrp_phy
  import ddrp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [BA_W-1:0] cmd_bank,
  input wire logic cmd_ras_n,
  input wire logic cmd_cas_n,
  input wire logic cmd_we_n,
  input wire logic cmd_cs_n,
  input wire logic cke_en,
  // write beats, one per clock
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic [NUM_LANES-1:0] wr_mask,
  // read window and captured bytes
  input wire logic rd_gate,
  output logic [DQ_W-1:0] rd_data,
  output logic [NUM_LANES-1:0] rd_valid,
  // clock phase indicators and clock manager setting
  output logic mem_clock_source,
  output logic ctrl_system_clock,
  output logic signed [PHASE_W-1:0] clock_manager_phase_shift,
  // memory pins
  output logic mem_clk_p,
  output logic mem_clk_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [BA_W-1:0] mem_bank,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic mem_cs_n,
  output logic mem_cke,
  input wire logic [DQ_W-1:0] mem_dq_i,
  output logic [DQ_W-1:0] mem_dq_o,
  output logic [DQ_W-1:0] mem_dq_oe,
  output logic [NUM_LANES-1:0] mem_dm,
  input wire logic [NUM_LANES-1:0] mem_dqs_i,
  output logic [NUM_LANES-1:0] mem_dqs_o,
  output logic [NUM_LANES-1:0] mem_dqs_oe,
  // reference keep pins, one pair per bank
  input wire logic [NUM_BANKS-1:0] dummy_keep_in,
  output logic [NUM_BANKS-1:0] dummy_keep_out
);

  // memory clock phase pair
  logic mclk, next_mclk;
  logic mclk_inv, next_mclk_inv;

  // command output registers
  logic [ADDR_W-1:0] addr_q, next_addr_q;
  logic [BA_W-1:0] bank_q, next_bank_q;
  logic ras_q, next_ras_q;
  logic cas_q, next_cas_q;
  logic we_q, next_we_q;
  logic cs_q, next_cs_q;
  logic cke_q, next_cke_q;
  logic cmd_fire;

  // write staging and strobe sequencer
  ddrp_wstate_t wst, next_wst;
  logic s1_v, next_s1_v;
  logic [DQ_W-1:0] s1_data, next_s1_data;
  logic [NUM_LANES-1:0] s1_mask, next_s1_mask;
  logic tgl, next_tgl;
  logic wr_fire;
  logic lane_load;

  // clock phases: both derived from the one reference clock
  always_comb
  begin
    next_mclk = ~mclk;
    next_mclk_inv = mclk;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mclk <= LEVEL_LOW;
      mclk_inv <= LEVEL_HIGH;
    end
    else
    begin
      mclk <= next_mclk;
      mclk_inv <= next_mclk_inv;
    end
  end

  // commands only taken on the falling memory clock edge
  assign cmd_ready = mclk;
  assign cmd_fire = cmd_valid && cmd_ready;

  // command next values, nop when nothing is offered
  always_comb
  begin
    next_addr_q = addr_q;
    next_bank_q = bank_q;
    next_ras_q = ras_q;
    next_cas_q = cas_q;
    next_we_q = we_q;
    next_cs_q = cs_q;
    next_cke_q = cke_q;
    if (mclk)
    begin
      // update on the control phase, midway between rising edges
      next_cke_q = cke_en;
      if (cmd_fire)
      begin
        next_addr_q = cmd_addr;
        next_bank_q = cmd_bank;
        next_ras_q = cmd_ras_n;
        next_cas_q = cmd_cas_n;
        next_we_q = cmd_we_n;
        next_cs_q = cmd_cs_n;
      end
      else
      begin
        next_ras_q = CMD_INACTIVE;
        next_cas_q = CMD_INACTIVE;
        next_we_q = CMD_INACTIVE;
        next_cs_q = CMD_INACTIVE;
      end
    end
  end

  // control phase output flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_q <= ADDR_RESET;
      bank_q <= BA_RESET;
      ras_q <= CMD_INACTIVE;
      cas_q <= CMD_INACTIVE;
      we_q <= CMD_INACTIVE;
      cs_q <= CMD_INACTIVE;
      cke_q <= LEVEL_LOW;
    end
    else
    begin
      addr_q <= next_addr_q;
      bank_q <= next_bank_q;
      ras_q <= next_ras_q;
      cas_q <= next_cas_q;
      we_q <= next_we_q;
      cs_q <= next_cs_q;
      cke_q <= next_cke_q;
    end
  end

  // first beat only when the next strobe high meets a falling memory clock
  always_comb
  begin
    unique case (wst)
      DDRP_W_IDLE: wr_ready = !mclk;
      DDRP_W_PRE: wr_ready = LEVEL_HIGH;
      DDRP_W_DATA: wr_ready = s1_v;
      DDRP_W_POST: wr_ready = LEVEL_LOW;
    endcase
  end
  assign wr_fire = wr_valid && wr_ready;

  // strobe sequencer: preamble, toggle per beat, postamble
  always_comb
  begin
    next_wst = wst;
    unique case (wst)
      DDRP_W_IDLE: if (wr_fire) next_wst = DDRP_W_PRE;
      DDRP_W_PRE: next_wst = DDRP_W_DATA;
      DDRP_W_DATA: if (!s1_v) next_wst = DDRP_W_POST;
      DDRP_W_POST: next_wst = DDRP_W_IDLE;
    endcase
    lane_load = (next_wst == DDRP_W_DATA);
    // strobe rises with the first beat, then flips on every beat
    if (next_wst == DDRP_W_DATA)
      next_tgl = (wst == DDRP_W_DATA) ? ~tgl : LEVEL_HIGH;
    else
      next_tgl = LEVEL_LOW;
    next_s1_v = wr_fire;
    next_s1_data = wr_fire ? wr_data : s1_data;
    next_s1_mask = wr_fire ? wr_mask : s1_mask;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wst <= DDRP_W_IDLE;
      tgl <= LEVEL_LOW;
      s1_v <= LEVEL_LOW;
      s1_data <= '0;
      s1_mask <= '0;
    end
    else
    begin
      wst <= next_wst;
      tgl <= next_tgl;
      s1_v <= next_s1_v;
      s1_data <= next_s1_data;
      s1_mask <= next_s1_mask;
    end
  end

  // byte lanes, each with its own strobe, mask and eight data bits
  generate
    for (genvar n = 0; n < NUM_LANES; n++)
    begin : g_lane
      ddrp_lane_if lif ();
      assign lif.wr_byte = s1_data[n*LANE_W +: LANE_W];
      assign lif.wr_mask = s1_mask[n];
      assign lif.wr_load = lane_load;
      assign lif.dqs_drive = (next_wst != DDRP_W_IDLE);
      assign lif.dqs_level = next_tgl;
      assign lif.rd_gate = rd_gate;
      assign lif.dq_i = mem_dq_i[n*LANE_W +: LANE_W];
      assign lif.dqs_i = mem_dqs_i[n];
      assign mem_dq_o[n*LANE_W +: LANE_W] = lif.dq_o;
      assign mem_dq_oe[n*LANE_W +: LANE_W] = {LANE_W{lif.dq_oe}};
      assign mem_dm[n] = lif.dm_o;
      assign mem_dqs_o[n] = lif.dqs_o;
      assign mem_dqs_oe[n] = lif.dqs_oe;
      assign rd_data[n*LANE_W +: LANE_W] = lif.rd_byte;
      assign rd_valid[n] = lif.rd_valid;
      ddrp_lane u_lane (
        .clk(clk),
        .arst_n(arst_n),
        .lif(lif)
      );
    end
  endgenerate

  // clock pins and phase indicators
  assign mem_clk_p = mclk;
  assign mem_clk_n = mclk_inv;
  assign mem_clock_source = mclk;
  assign ctrl_system_clock = mclk_inv;
  assign clock_manager_phase_shift = CLOCK_MANAGER_PHASE_SHIFT;

  // command pins from the control phase flops
  assign mem_addr = addr_q;
  assign mem_bank = bank_q;
  assign mem_ras_n = ras_q;
  assign mem_cas_n = cas_q;
  assign mem_we_n = we_q;
  assign mem_cs_n = cs_q;
  assign mem_cke = cke_q;

  // reference keep path, no logic so it cannot be trimmed away
  assign dummy_keep_out = dummy_keep_in;

endmodule // ddrp_phy

// file: hdl/ddrp_pkg.sv
// shared constants and types for the ddr phy clocking and i/o block
package ddrp_pkg;

  // pin group widths
  localparam int DQ_W = 32;
  localparam int LANE_W = 8;
  localparam int NUM_LANES = DQ_W / LANE_W;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 2;

  // memory clock figures as documented, and the local clock period
  localparam int MEM_CLK_MHZ = 200;
  localparam int MEM_PERIOD_NS = 5;
  localparam int CLK_PERIOD_NS = 4;

  // fixed phase shift setting handed to the clock manager
  localparam int PHASE_W = 10;
  localparam logic signed [PHASE_W-1:0] CLOCK_MANAGER_PHASE_SHIFT = 10'sh0b6;

  // reset and idle levels
  localparam logic CMD_INACTIVE = 1'h1;
  localparam logic LEVEL_LOW = 1'h0;
  localparam logic LEVEL_HIGH = 1'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
  localparam logic [BA_W-1:0] BA_RESET = 2'h0;
  localparam logic [LANE_W-1:0] BYTE_RESET = 8'h00;

  // write strobe sequencer, gray coded along idle-pre-data-post
  typedef enum logic [1:0] {
    DDRP_W_IDLE = 2'h0,
    DDRP_W_PRE  = 2'h1,
    DDRP_W_DATA = 2'h3,
    DDRP_W_POST = 2'h2
  } ddrp_wstate_t;

endpackage

// file: hdl/ddrp_lane_if.sv
// byte lane carrier between the phy core and one lane slice
`timescale 1ns/1ps
interface ddrp_lane_if;
  import ddrp_pkg::*;
  // write side, next values computed by the core
  logic [LANE_W-1:0] wr_byte;
  logic wr_mask;
  logic wr_load;
  logic dqs_drive;
  logic dqs_level;
  logic rd_gate;
  // lane pins
  logic [LANE_W-1:0] dq_i;
  logic dqs_i;
  logic [LANE_W-1:0] dq_o;
  logic dq_oe;
  logic dm_o;
  logic dqs_o;
  logic dqs_oe;
  // read results
  logic [LANE_W-1:0] rd_byte;
  logic rd_valid;

  modport core (
    output wr_byte, wr_mask, wr_load, dqs_drive, dqs_level, rd_gate, dq_i, dqs_i,
    input dq_o, dq_oe, dm_o, dqs_o, dqs_oe, rd_byte, rd_valid
  );
  modport lane (
    input wr_byte, wr_mask, wr_load, dqs_drive, dqs_level, rd_gate, dq_i, dqs_i,
    output dq_o, dq_oe, dm_o, dqs_o, dqs_oe, rd_byte, rd_valid
  );
endinterface // ddrp_lane_if

// file: hdl/ddrp_lane.sv
// one byte lane slice: write launch registers and strobe-timed read capture
`timescale 1ns/1ps
module ddrp_lane
  import ddrp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  ddrp_lane_if.lane lif
);

  logic [LANE_W-1:0] dq_o, next_dq_o;
  logic dq_oe, next_dq_oe;
  logic dm_o, next_dm_o;
  logic dqs_o, next_dqs_o;
  logic dqs_oe, next_dqs_oe;
  logic dqs_d1, dqs_d2;
  logic [LANE_W-1:0] dq_d1;
  logic gate_d1;
  logic [LANE_W-1:0] rd_byte, next_rd_byte;
  logic rd_valid, next_rd_valid;

  // write launch and read capture next values
  always_comb
  begin
    next_dq_o = lif.wr_load ? lif.wr_byte : dq_o;
    next_dm_o = lif.wr_load ? lif.wr_mask : dm_o;
    next_dq_oe = lif.wr_load;
    next_dqs_oe = lif.dqs_drive;
    next_dqs_o = lif.dqs_level;
    // own lane strobe only, one register of delay before edge detect
    next_rd_valid = gate_d1 && !dqs_oe && (dqs_d1 != dqs_d2);
    next_rd_byte = next_rd_valid ? dq_d1 : rd_byte;
  end

  // lane registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dq_o <= BYTE_RESET;
      dq_oe <= LEVEL_LOW;
      dm_o <= LEVEL_LOW;
      dqs_o <= LEVEL_LOW;
      dqs_oe <= LEVEL_LOW;
      dqs_d1 <= LEVEL_LOW;
      dqs_d2 <= LEVEL_LOW;
      dq_d1 <= BYTE_RESET;
      gate_d1 <= LEVEL_LOW;
      rd_byte <= BYTE_RESET;
      rd_valid <= LEVEL_LOW;
    end
    else
    begin
      dq_o <= next_dq_o;
      dq_oe <= next_dq_oe;
      dm_o <= next_dm_o;
      dqs_o <= next_dqs_o;
      dqs_oe <= next_dqs_oe;
      dqs_d1 <= lif.dqs_i; // delayed strobe copy
      dqs_d2 <= dqs_d1;
      dq_d1 <= lif.dq_i;
      gate_d1 <= lif.rd_gate;
      rd_byte <= next_rd_byte;
      rd_valid <= next_rd_valid;
    end
  end

  // lane outputs straight from registers
  assign lif.dq_o = dq_o;
  assign lif.dq_oe = dq_oe;
  assign lif.dm_o = dm_o;
  assign lif.dqs_o = dqs_o;
  assign lif.dqs_oe = dqs_oe;
  assign lif.rd_byte = rd_byte;
  assign lif.rd_valid = rd_valid;

endmodule // ddrp_lane

// file: test/ddrp_mem.sv
// memory-side read model: per-lane strobes returned with read data
`timescale 1ns/1ps
module ddrp_mem
  import ddrp_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [NUM_LANES-1:0] lanes,
  output logic [DQ_W-1:0] dq,
  output logic [NUM_LANES-1:0] dqs
);
  logic [2:0] beat;
  initial
  begin
    beat = 3'h4;
    dq = 32'h0000_0000;
    dqs = 4'h0;
  end
  // four beats, one strobe edge each on the selected lanes
  always @(posedge clk)
  begin
    if (go && beat == 3'h4)
      beat <= 3'h0;
    else if (beat != 3'h4)
    begin
      beat <= beat + 3'h1;
      dqs <= dqs ^ lanes;
      dq <= 32'h4030_2010 + {4{5'h00, beat}};
    end
    else
      dq <= ~dq; // released bus inverts its last value on every idle clock (beat at 4) that go is low
  end
endmodule // ddrp_mem

// file: test/ddrp_chk.sv
// assertion checker bound to the phy top
`timescale 1ns/1ps
module ddrp_chk
  import ddrp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_ras_n,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic rd_gate,
  input wire logic [DQ_W-1:0] rd_data,
  input wire logic [NUM_LANES-1:0] rd_valid,
  input wire logic mem_clock_source,
  input wire logic ctrl_system_clock,
  input wire logic signed [PHASE_W-1:0] clock_manager_phase_shift,
  input wire logic mem_clk_p,
  input wire logic mem_clk_n,
  input wire logic mem_ras_n,
  input wire logic [DQ_W-1:0] mem_dq_i,
  input wire logic [DQ_W-1:0] mem_dq_oe,
  input wire logic [NUM_LANES-1:0] mem_dqs_i,
  input wire logic [NUM_LANES-1:0] mem_dqs_o,
  input wire logic [NUM_LANES-1:0] mem_dqs_oe,
  input wire logic [NUM_BANKS-1:0] dummy_keep_in,
  input wire logic [NUM_BANKS-1:0] dummy_keep_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // write preamble, then first driven beat
  sequence wr_pre;
    mem_dqs_oe == 4'hf && mem_dqs_o == 4'h0;
  endsequence
  sequence wr_beat0;
    mem_dq_oe == 32'hffff_ffff && mem_dqs_o == 4'hf;
  endsequence
  clk_pair_a: assert property (mem_clk_n != mem_clk_p)
    else $error("clock pair equal");
  clk_toggle_a: assert property (1 |=> mem_clk_p != $past(mem_clk_p))
    else $error("memory clock stalled");
  ctrl_phase_a: assert property (mem_clock_source == mem_clk_p && ctrl_system_clock != mem_clk_p)
    else $error("clock phases wrong");
  phase_set_a: assert property (clock_manager_phase_shift == 10'sh0b6)
    else $error("phase setting wrong");
  ready_phase_a: assert property (cmd_ready == mem_clk_p)
    else $error("ready off phase");
  cmd_take_a: assert property (cmd_valid && cmd_ready |=> mem_ras_n == $past(cmd_ras_n) && !mem_clk_p)
    else $error("command not launched");
  cmd_hold_a: assert property (!mem_clk_p && $past(mem_clk_p) |=> $stable(mem_ras_n))
    else $error("command moved early");
  keep_copy_a: assert property (dummy_keep_out == dummy_keep_in)
    else $error("keep pin not copied");
  wr_start_a: assert property (wr_valid && wr_ready && mem_dqs_oe == 4'h0 |=> wr_pre ##1 wr_beat0)
    else $error("write strobe wrong");
  rd_take_a: assert property ($changed(mem_dqs_i[0]) && rd_gate && $past(rd_gate)
    && !mem_dqs_oe[0] |-> ##2 rd_valid[0] && rd_data[7:0] == $past(mem_dq_i[7:0], 2))
    else $error("lane capture missed");
  rd_lane_a: assert property (rd_valid[2] |-> $past(mem_dqs_i[2], 2) != $past(mem_dqs_i[2], 3))
    else $error("capture without strobe");
endmodule // ddrp_chk

bind ddrp_phy ddrp_chk u_ddrp_chk (.clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_ras_n,
  .wr_valid, .wr_ready, .rd_gate, .rd_data, .rd_valid, .mem_clock_source,
  .ctrl_system_clock, .clock_manager_phase_shift, .mem_clk_p, .mem_clk_n, .mem_ras_n,
  .mem_dq_i, .mem_dq_oe, .mem_dqs_i, .mem_dqs_o, .mem_dqs_oe, .dummy_keep_in,
  .dummy_keep_out);

// file: test/tb.sv
// testbench for the ddr phy clocking block
`timescale 1ns/1ps
module tb
  import ddrp_pkg::*;
;
  logic clk, arst_n, cmd_valid, cmd_ready, cmd_ras_n, cmd_cas_n, cmd_we_n, cmd_cs_n;
  logic cke_en, wr_valid, wr_ready, rd_gate, mem_clock_source, ctrl_system_clock;
  logic mem_clk_p, mem_clk_n, mem_ras_n, mem_cas_n, mem_we_n, mem_cs_n, mem_cke, go;
  logic [ADDR_W-1:0] cmd_addr, mem_addr;
  logic [BA_W-1:0] cmd_bank, mem_bank;
  logic [DQ_W-1:0] wr_data, rd_data, mem_dq_i, mem_dq_o, mem_dq_oe;
  logic [NUM_LANES-1:0] wr_mask, rd_valid, mem_dm, mem_dqs_i, mem_dqs_o, mem_dqs_oe, sel;
  logic signed [PHASE_W-1:0] clock_manager_phase_shift;
  logic [NUM_BANKS-1:0] dummy_keep_in, dummy_keep_out;
  int failures, tests_run;
  int pulses [NUM_LANES];

  ddrp_phy u_ddrp_phy (.clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_addr, .cmd_bank,
    .cmd_ras_n, .cmd_cas_n, .cmd_we_n, .cmd_cs_n, .cke_en, .wr_valid, .wr_ready, .wr_data,
    .wr_mask, .rd_gate, .rd_data, .rd_valid, .mem_clock_source, .ctrl_system_clock,
    .clock_manager_phase_shift, .mem_clk_p, .mem_clk_n, .mem_addr, .mem_bank, .mem_ras_n,
    .mem_cas_n, .mem_we_n, .mem_cs_n, .mem_cke, .mem_dq_i, .mem_dq_o, .mem_dq_oe, .mem_dm,
    .mem_dqs_i, .mem_dqs_o, .mem_dqs_oe, .dummy_keep_in, .dummy_keep_out);
  ddrp_mem u_ddrp_mem (.clk, .go, .lanes(sel), .dq(mem_dq_i), .dqs(mem_dqs_i));

  // clock and capture pulse counting
  always #2 clk = ~clk;
  always @(posedge clk)
    for (int i = 0; i < NUM_LANES; i++)
      if (rd_valid[i] === 1'b1)
        pulses[i]++;

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // clock pair, phases and shift setting
  task automatic t_clocks();
    logic prev;
    @(negedge clk);
    prev = mem_clk_p;
    repeat (4)
    begin
      @(negedge clk);
      check(mem_clk_p, !prev, "toggle");
      check(mem_clk_n, prev, "pair");
      check({mem_clock_source, ctrl_system_clock}, {!prev, prev}, "phase");
      prev = mem_clk_p;
    end
    check(clock_manager_phase_shift, 40'h00b6, "shift");
    $display("clocks done");
  endtask

  // one command, then hold and nop
  task automatic t_cmd();
    @(negedge clk);
    while (cmd_ready !== 1'b0)
      @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    {cmd_ras_n, cmd_cas_n, cmd_we_n, cmd_cs_n, cke_en} <= 5'h09;
    {cmd_addr, cmd_bank} <= {13'h1abc, 2'h2};
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2)
    begin
      @(negedge clk);
      check({mem_ras_n, mem_cas_n, mem_we_n, mem_cs_n, mem_cke}, 5'h09, "cmd");
      check({mem_addr, mem_bank, mem_clk_p}, {13'h1abc, 2'h2, mem_clk_p}, "addr");
    end
    @(negedge clk);
    check({mem_ras_n, mem_cas_n, mem_we_n, mem_cs_n, mem_addr}, {4'hf, 13'h1abc}, "nop");
    $display("command done");
  endtask

  // two-beat write burst with strobe framing
  task automatic t_write();
    @(negedge clk);
    while (mem_clk_p !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    {wr_valid, wr_data, wr_mask} <= {1'b1, 32'ha5a5_0f0f, 4'h0};
    @(posedge clk);
    {wr_data, wr_mask} <= {32'h5a5a_f0f0, 4'h5};
    @(negedge clk);
    check(wr_ready, 1'b1, "beat refused");
    check({mem_dqs_oe, mem_dqs_o, mem_dq_oe}, 40'hf0_0000_0000, "preamble");
    @(posedge clk);
    wr_valid <= 1'b0;
    @(negedge clk);
    check({mem_dqs_oe, mem_dqs_o, mem_dq_oe}, 40'hff_ffff_ffff, "beat0 oe");
    check({mem_dm, mem_dq_o}, 36'h0_a5a5_0f0f, "beat0");
    @(negedge clk);
    check({mem_dqs_oe, mem_dqs_o, mem_dq_oe}, 40'hf0_ffff_ffff, "beat1 oe");
    check({mem_dm, mem_dq_o}, 36'h5_5a5a_f0f0, "beat1");
    @(negedge clk);
    check({mem_dqs_oe, mem_dqs_o, mem_dq_oe}, 40'hf0_0000_0000, "postamble");
    @(negedge clk);
    check({mem_dqs_oe, mem_dq_oe}, 36'h0, "release");
    $display("write done");
  endtask

  // read burst on chosen lanes, each lane on its own strobe
  task automatic t_read(input logic [3:0] lanes);
    @(negedge clk);
    foreach (pulses[i])
      pulses[i] = 0;
    @(posedge clk);
    {rd_gate, sel, go} <= {1'b1, lanes, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    repeat (8)
      @(posedge clk);
    rd_gate <= 1'b0;
    @(negedge clk);
    check(rd_data, 32'h4333_2313, "read data");
    foreach (pulses[i])
      check(pulses[i], lanes[i] ? 4 : 0, "captures");
    $display("read done");
  endtask

  // reference keep pins copied straight through
  task automatic t_keep();
    for (int v = 1; v < 3; v++)
    begin
      @(posedge clk);
      dummy_keep_in <= v[1:0];
      @(negedge clk);
      check(dummy_keep_out, v[1:0], "keep");
    end
    $display("keep done");
  endtask

  initial
  begin
    {clk, arst_n, cmd_valid, cke_en, wr_valid, rd_gate, go} = '0;
    {cmd_ras_n, cmd_cas_n, cmd_we_n, cmd_cs_n} = 4'hf;
    {cmd_addr, cmd_bank, wr_data, wr_mask, sel, dummy_keep_in} = '0;
    repeat (16)
      @(posedge clk);
    // idle levels while held in reset
    check({mem_clk_p, mem_clk_n, cmd_ready, mem_cke, mem_ras_n}, 5'h09, "reset");
    arst_n <= 1'b1;
    t_clocks();
    t_cmd();
    t_write();
    t_read(4'hf);
    t_read(4'h4);
    t_keep();
    wrap_up();
  end

  // watchdog well beyond the expected run
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule // tb
